// *** rtl/ard_pkg.sv ***
// Package for the converter result and display data path
package ard_pkg;

  // ----------------------------------------------------------------
  // Register select indices of the register access port
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_OFFSET = 3'h0;
  localparam logic [2:0] SEL_RES_UP = 3'h1;
  localparam logic [2:0] SEL_DISP   = 3'h2;
  localparam logic [2:0] SEL_PEAK   = 3'h3;
  localparam logic [2:0] SEL_RES_LO = 3'h4;

  // ----------------------------------------------------------------
  // Widths, field positions and reset values
  // ----------------------------------------------------------------
  localparam int          REG_W        = 16;
  localparam int          RES_W        = 20;
  localparam int          LO_W         = 8;
  localparam int          SUB_BITS     = 4;
  localparam int          LO_FIELD_POS = 4;
  localparam logic [15:0] OFFSET_RST   = 16'h0000;
  localparam logic [15:0] RES_UP_RST   = 16'h0000;
  localparam logic [15:0] DISP_RST     = 16'h0000;
  localparam logic [15:0] PEAK_RST     = 16'h0000;
  localparam logic [7:0]  RES_LO_RST   = 8'h00;

  // Peak tracking is only guaranteed inside these counts
  localparam int PEAK_MIN_45 = -19487;
  localparam int PEAK_MAX_45 = 19999;
  localparam int PEAK_MIN_35 = -1217;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [2:0]  sel;
    logic [15:0] wdata;
  } ard_reg_req_t;

  typedef struct packed {
    logic src_serial;
    logic peak;
    logic hold;
    logic auto_calibration_disable;
    logic enhanced_calibration_trigger;
    logic digital_powerdown;
    logic analog_powerdown;
    logic range_select;
  } ard_ctrl_t;

  typedef struct packed {
    logic filter_run;
    logic display_run;
    logic modulator_run;
    logic buffer_run;
  } ard_power_t;

endpackage : ard_pkg

// *** rtl/ard_result_path.sv ***
// Result, peak and display data path of a sigma-delta panel-meter converter
`timescale 1ns/100ps
// Overview of operation
// [R1] Signed 16-bit user offset register, reset zero
// [R2] Result equals calibrated input minus user offset
// [R3] Upper result register holds sixteen result MSBs
// [R4] Short variant uses bits fifteen down to four
// [R5] Lower register: four LSBs in upper nibble
// [R6] Display loads from result, peak or serial
// [R7] Short variant display/peak LSB at bit four
// [R8] Peak: first copy, then keep larger results
// [R9] Clearing peak enable clears peak register
// [R10] Peak valid only inside documented count range
// [R11] Power-up reset returns all registers to defaults
// [R12] Offset calibration each conversion unless disabled
// [R13] Enhanced calibration runs when trigger set
// [R14] Digital and analog power-down act independently
// [R15] Peak mode shows only the highest value
// [R16] Hold freezes the reading present at activation
// [R17] Low battery sets flag and segment; the segment is held off during digital power-down
// [R18] Both result registers update from one conversion
module ard_result_path
  import ard_pkg::*;
#(
  parameter bit THREE_HALF = 1'b0,
  parameter int RESULT_W   = RES_W
) (
  // Clock and reset
  input  wire logic         CLK_SYS,
  input  wire logic         RESET_N,
  // Register access port
  input  wire ard_reg_req_t REG_REQ,
  output logic [15:0]       REG_RDATA,
  output logic              REG_RVALID,
  // Control bits and conversion input
  input  wire ard_ctrl_t    CTRL,
  input  wire logic         CONV_VALID,
  input  wire logic [19:0]  CONV_CALIBRATED,
  input  wire logic         LOW_BATT_BELOW,
  // Display and status
  output logic [15:0]       DISPLAY_DATA,
  output logic              LOW_SUPPLY_FLAG,
  output logic              LOW_SUPPLY_FLAG_SEGMENT,
  // Calibration and power control
  output logic              OFFSET_CAL_RUN,
  output logic              ENH_CAL_START,
  output ard_power_t        POWER
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (RESULT_W != RES_W) begin : g_bad_width
    $error("Result path only serves a 20-bit result");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] user_offset_correction;
  logic [15:0] conversion_result_upper;
  logic [7:0]  conversion_result_lower;
  logic [7:0]  lower_snapshot;
  logic [15:0] display_value;
  logic [15:0] max_value_tracker;
  logic        peak_loaded;
  logic        trig_d;
  logic        conv_taken;
  logic        snap_held;

  // ----------------------------------------------------------------
  // Result arithmetic
  // ----------------------------------------------------------------
  // Offset is aligned to the LSB of the upper result register
  wire logic [19:0] offset_ext  = {user_offset_correction, {SUB_BITS{1'b0}}};
  wire logic [19:0] raw_final   = CONV_CALIBRATED - offset_ext; // [R2]
  wire logic [3:0]  sub_mask    = THREE_HALF ? 4'h0 : 4'hf;
  wire logic [15:0] next_upper  = {raw_final[19:8], raw_final[7:4] & sub_mask}; // [R3] [R4]
  wire logic [7:0]  next_lower  = {raw_final[3:0] & sub_mask, 4'h0}; // [R5]
  // Filter stopped means no new results are taken at all
  wire logic        take_conv   = CONV_VALID & ~CTRL.digital_powerdown; // [R14]
  wire logic        peak_bigger = $signed(next_upper) > $signed(max_value_tracker);
  wire logic        peak_load   = take_conv & CTRL.peak & (~peak_loaded | peak_bigger);
  wire logic [15:0] next_peak   = peak_load ? next_upper : max_value_tracker;

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  wire logic wr_offset = REG_REQ.req & REG_REQ.wr & (REG_REQ.sel == SEL_OFFSET);
  wire logic wr_disp   = REG_REQ.req & REG_REQ.wr & (REG_REQ.sel == SEL_DISP);
  wire logic rd_upper  = REG_REQ.req & ~REG_REQ.wr & (REG_REQ.sel == SEL_RES_UP);
  wire logic rd_lower  = REG_REQ.req & ~REG_REQ.wr & (REG_REQ.sel == SEL_RES_LO);
  // Serial writes reach the display only in serial mode outside hold or peak
  wire logic serial_ok = CTRL.src_serial & ~CTRL.hold & ~CTRL.peak;

  logic [15:0] next_rdata;
  always_comb begin
    case (REG_REQ.sel)
      SEL_OFFSET: next_rdata = user_offset_correction;
      SEL_RES_UP: next_rdata = conversion_result_upper;
      SEL_DISP:   next_rdata = display_value;
      SEL_PEAK:   next_rdata = max_value_tracker;
      SEL_RES_LO: next_rdata = {8'h00, rd_snap_sel()};
      default:    next_rdata = 16'h0000;
    endcase
  end

  // Lower byte comes from the snapshot taken when the upper half was read
  function automatic logic [7:0] rd_snap_sel();
    rd_snap_sel = lower_snapshot;
  endfunction : rd_snap_sel

  // ----------------------------------------------------------------
  // Offset register and read port
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      user_offset_correction <= OFFSET_RST; // [R1] [R11]
      REG_RDATA              <= 16'h0000;
      REG_RVALID             <= 1'b0;
    end else begin
      if (wr_offset) begin
        user_offset_correction <= REG_REQ.wdata; // [R1]
      end
      REG_RVALID <= REG_REQ.req & ~REG_REQ.wr;
      if (REG_REQ.req && !REG_REQ.wr) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Both halves load on one edge; the snapshot keeps a read pair coherent
  // even when a conversion lands between the two reads
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      conversion_result_upper <= RES_UP_RST; // [R11]
      conversion_result_lower <= RES_LO_RST;
      lower_snapshot          <= RES_LO_RST;
      conv_taken              <= 1'b0;
      snap_held               <= 1'b0;
    end else begin
      conv_taken <= take_conv;
      // An upper read pins the snapshot until the lower half is read
      if (rd_upper) begin
        snap_held <= 1'b1; // [R18]
      end else if (rd_lower) begin
        snap_held <= 1'b0;
      end
      if (take_conv) begin
        conversion_result_upper <= next_upper; // [R18]
        conversion_result_lower <= next_lower; // [R18]
      end
      if (rd_upper) begin
        lower_snapshot <= conversion_result_lower; // [R18]
      end else if (take_conv && !snap_held) begin
        lower_snapshot <= next_lower; // [R18]
      end
    end
  end

  // ----------------------------------------------------------------
  // Peak tracker
  // ----------------------------------------------------------------
  // Tracking beyond the guaranteed count range may wrap; not corrected
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      max_value_tracker <= PEAK_RST; // [R11]
      peak_loaded       <= 1'b0;
    end else if (!CTRL.peak) begin
      max_value_tracker <= PEAK_RST; // [R9]
      peak_loaded       <= 1'b0;
    end else if (peak_load) begin
      max_value_tracker <= next_upper; // [R8] [R7] [R10]
      peak_loaded       <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Display data register
  // ----------------------------------------------------------------
  // Priority: hold freezes, then peak, then serial, then live result
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      display_value <= DISP_RST; // [R11]
    end else if (CTRL.hold) begin
      display_value <= display_value; // [R16]
    end else if (CTRL.peak) begin
      display_value <= next_peak; // [R15] [R6]
    end else if (CTRL.src_serial) begin
      if (wr_disp && serial_ok) begin
        display_value <= REG_REQ.wdata; // [R6]
      end
    end else if (take_conv) begin
      display_value <= next_upper; // [R6] [R7]
    end
  end

  // ----------------------------------------------------------------
  // Display drive, low battery, calibration and power control
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      DISPLAY_DATA    <= DISP_RST;
      LOW_SUPPLY_FLAG <= 1'b0;
      LOW_SUPPLY_FLAG_SEGMENT <= 1'b0;
      OFFSET_CAL_RUN  <= 1'b0;
      ENH_CAL_START   <= 1'b0;
      trig_d          <= 1'b0;
      POWER           <= '0;
    end else begin
      DISPLAY_DATA    <= display_value;
      LOW_SUPPLY_FLAG <= LOW_BATT_BELOW; // [R17]
      LOW_SUPPLY_FLAG_SEGMENT <= LOW_BATT_BELOW & ~CTRL.digital_powerdown; // [R17]
      // Calibration is part of each conversion, so it needs the modulator
      OFFSET_CAL_RUN  <= ~CTRL.auto_calibration_disable & ~CTRL.analog_powerdown; // [R12]
      trig_d          <= CTRL.enhanced_calibration_trigger;
      // Rising edge only: a held trigger bit starts one run, not many
      ENH_CAL_START   <= CTRL.enhanced_calibration_trigger & ~trig_d; // [R13]
      POWER.filter_run    <= ~CTRL.digital_powerdown; // [R14]
      POWER.display_run   <= ~CTRL.digital_powerdown; // [R14]
      POWER.modulator_run <= ~CTRL.analog_powerdown; // [R14]
      POWER.buffer_run    <= ~CTRL.analog_powerdown; // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  sequence s_peak_first;
    CTRL.peak && !peak_loaded && take_conv;
  endsequence

  sequence s_peak_next;
    CTRL.peak && peak_loaded && take_conv && !peak_bigger;
  endsequence

  sequence s_peak_grow;
    CTRL.peak && peak_loaded && take_conv && peak_bigger;
  endsequence

  a_peak_grow: // [R8]
    assert property (s_peak_grow |=> max_value_tracker == $past(next_upper))
    else $error("Peak not raised by a larger result");

  a_snap_hold: // [R18]
    assert property (snap_held && !rd_upper |=> $stable(lower_snapshot))
    else $error("Lower snapshot torn after upper read");

  a_serial_write: // [R6]
    assert property (wr_disp && serial_ok |=> display_value == $past(REG_REQ.wdata))
    else $error("Serial display write not stored");

  a_serial_refused: // [R6]
    assert property (wr_disp && !CTRL.src_serial && !CTRL.peak && !take_conv |=> $stable(display_value))
    else $error("Display written outside serial mode");

  a_live_display: // [R6]
    assert property (take_conv && !CTRL.hold && !CTRL.peak && !CTRL.src_serial |=>
      display_value == $past(next_upper))
    else $error("Live display not loaded from result");

  a_low_segment: // [R17]
    assert property (LOW_BATT_BELOW && !CTRL.digital_powerdown |=> LOW_SUPPLY_FLAG_SEGMENT)
    else $error("Low battery segment not on");

  a_cal_run: // [R12]
    assert property (!CTRL.auto_calibration_disable && !CTRL.analog_powerdown |=> OFFSET_CAL_RUN)
    else $error("Offset calibration not running");

  a_cal_stop: // [R12]
    assert property (CTRL.auto_calibration_disable |=> !OFFSET_CAL_RUN)
    else $error("Offset calibration runs while disabled");

  a_cal_edge: // [R13]
    assert property (CTRL.enhanced_calibration_trigger && !trig_d |=> ENH_CAL_START)
    else $error("Enhanced calibration not started");

  a_filter_halt: // [R14]
    assert property (CTRL.digital_powerdown && CONV_VALID |=> $stable(conversion_result_upper))
    else $error("Result taken while filter powered down");

  a_analog_split: // [R14]
    assert property (CTRL.analog_powerdown && !CTRL.digital_powerdown |=>
      POWER.filter_run && !POWER.modulator_run)
    else $error("Analog power-down not independent");

  a_offset_write: // [R1]
    assert property (wr_offset |=> user_offset_correction == $past(REG_REQ.wdata))
    else $error("Offset write not stored");

  a_result_diff: // [R2]
    assert property (take_conv && !THREE_HALF |=>
      {conversion_result_upper, conversion_result_lower[7:4]} ==
      $past(CONV_CALIBRATED) - {$past(user_offset_correction), 4'h0})
    else $error("Result is not input minus offset");

  a_short_lsbs: // [R4]
    assert property (THREE_HALF |-> conversion_result_upper[3:0] == 4'h0)
    else $error("Short variant sub-bits not zero");

  a_lower_nibble: // [R5]
    assert property (conversion_result_lower[3:0] == 4'h0)
    else $error("Lower result low nibble not zero");

  a_peak_first: // [R8]
    assert property (s_peak_first |=> max_value_tracker == $past(next_upper) && peak_loaded)
    else $error("Peak not loaded with first result");

  a_peak_keep: // [R8]
    assert property (s_peak_next ##1 CTRL.peak |-> $stable(max_value_tracker))
    else $error("Peak changed on a smaller result");

  a_peak_clear: // [R9]
    assert property (!CTRL.peak |=> max_value_tracker == 16'h0000 && !peak_loaded)
    else $error("Peak not cleared");

  a_hold_freeze: // [R16]
    assert property (CTRL.hold [*2] |-> $stable(display_value))
    else $error("Display changed during hold");

  a_peak_display: // [R15]
    assert property (CTRL.peak && !CTRL.hold |=> display_value == max_value_tracker)
    else $error("Peak mode display differs from peak");

  a_low_battery: // [R17]
    assert property (LOW_BATT_BELOW |=> LOW_SUPPLY_FLAG ##1 DISPLAY_DATA == $past(display_value))
    else $error("Low supply flag not raised");

  a_cal_pulse: // [R13]
    assert property (ENH_CAL_START |=> !ENH_CAL_START)
    else $error("Enhanced calibration start longer than one cycle");

  a_pair_update: // [R18]
    assert property (conv_taken && !THREE_HALF |->
      conversion_result_lower[7:4] == $past(raw_final[3:0]))
    else $error("Result halves from different conversions");

  a_powerdown_split: // [R14]
    assert property (CTRL.digital_powerdown && !CTRL.analog_powerdown |=>
      !POWER.filter_run && POWER.modulator_run)
    else $error("Power-down controls not independent");

endmodule : ard_result_path

// *** testbench/ard_host_model.sv ***
// Microcontroller model that reaches the result path registers
`timescale 1ns/100ps
module ard_host_model
  import ard_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output ard_reg_req_t     req,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  initial req = '0;

  // ----------------------------------------------------------------
  // One access: fields are scrambled on release so stale data never passes
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [2:0] sel, input logic [15:0] wd,
                        output logic [15:0] rd);
    @(posedge clk);
    req <= '{req: 1'b1, wr: wr, sel: sel, wdata: wd};
    @(posedge clk);
    req <= '{req: 1'b0, wr: ~wr, sel: ~sel, wdata: ~wd};
    #1;
    rd = (rvalid === 1'b1) ? rdata : 16'hxxxx;
  endtask : access
endmodule : ard_host_model

// *** testbench/adc_result_display_data_path_test.sv ***
// Self-checking bench of the converter result and display data path
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %0t got %h exp %h", $time, (got), (exp)); end end
module adc_result_display_data_path_test
  import ard_pkg::*;
;
  logic         clk;
  logic         rst_n;
  ard_reg_req_t req;
  logic [15:0]  rdata;
  logic [15:0]  disp;
  logic [15:0]  rd;
  logic         rvalid;
  logic         cv;
  logic         lbb;
  logic         lsf;
  logic         lseg;
  logic         ocr;
  logic         ecs;
  logic [19:0]  cal;
  ard_ctrl_t    ctrl;
  ard_power_t   pwr;
  int           n_errors;
  int           compares;

  ard_result_path u_dut (.CLK_SYS(clk), .RESET_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .CTRL(ctrl), .CONV_VALID(cv), .CONV_CALIBRATED(cal),
    .LOW_BATT_BELOW(lbb), .DISPLAY_DATA(disp), .LOW_SUPPLY_FLAG(lsf),
    .LOW_SUPPLY_FLAG_SEGMENT(lseg), .OFFSET_CAL_RUN(ocr), .ENH_CAL_START(ecs), .POWER(pwr));
  ard_host_model u_host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // ----------------------------------------------------------------
  // Access and stimulus helpers
  // ----------------------------------------------------------------
  task automatic rd_chk(input logic [2:0] sel, input logic [15:0] exp);
    u_host.access(1'b0, sel, 16'h0000, rd);
    `CHK(rd, exp)
  endtask : rd_chk

  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    u_host.access(1'b1, sel, d, rd);
  endtask : wr

  // Display copy lands one edge after the registers, so wait past it
  task automatic conv(input logic [19:0] v);
    @(posedge clk);
    cv  <= 1'b1;
    cal <= v;
    @(posedge clk);
    cv  <= 1'b0;
    cal <= ~v;
    @(posedge clk);
    #1;
  endtask : conv

  task automatic setc(input ard_ctrl_t c);
    @(posedge clk);
    ctrl <= c;
    repeat (2) @(posedge clk);
    #1;
  endtask : setc

  task automatic final_report;
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0; cv = 1'b0; cal = '0; lbb = 1'b0; ctrl = '0;
    n_errors = 0; compares = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int s = 0; s < 6; s++) rd_chk(s[2:0], 16'h0000);
    `CHK(disp, 16'h0000)
    `CHK(pwr, 4'hf)
    `CHK(ocr, 1'b1)
    wr(SEL_OFFSET, 16'h0002);
    rd_chk(SEL_OFFSET, 16'h0002);
    wr(SEL_RES_UP, 16'h5555);
    conv(20'h12345);
    rd_chk(SEL_RES_UP, 16'h1232);
    rd_chk(SEL_RES_LO, 16'h0050);
    `CHK(disp, 16'h1232)
    conv(20'h00000);
    rd_chk(SEL_RES_UP, 16'hfffe);
    rd_chk(SEL_RES_LO, 16'h0000);
    wr(SEL_OFFSET, 16'h0000);
    // A conversion between the two reads must not tear the value
    conv(20'h0000a);
    rd_chk(SEL_RES_UP, 16'h0000);
    conv(20'h00005);
    rd_chk(SEL_RES_LO, 16'h00a0);
    setc('{peak: 1'b1, default: 1'b0});
    conv(20'h00100);
    rd_chk(SEL_PEAK, 16'h0010);
    conv(20'h00050);
    rd_chk(SEL_PEAK, 16'h0010);
    `CHK(disp, 16'h0010)
    conv(20'hfff00);
    conv(20'h00200);
    rd_chk(SEL_PEAK, 16'h0020);
    `CHK(disp, 16'h0020)
    setc('0);
    rd_chk(SEL_PEAK, 16'h0000);
    conv(20'h00300);
    `CHK(disp, 16'h0030)
    setc('{hold: 1'b1, default: 1'b0});
    conv(20'h00400);
    `CHK(disp, 16'h0030)
    rd_chk(SEL_RES_UP, 16'h0040);
    setc('{src_serial: 1'b1, default: 1'b0});
    wr(SEL_DISP, 16'h1234);
    rd_chk(SEL_DISP, 16'h1234);
    conv(20'h00500);
    `CHK(disp, 16'h1234)
    @(posedge clk);
    lbb <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({lsf, lseg}, 2'b11)
    lbb <= 1'b0;
    setc('{auto_calibration_disable: 1'b1, default: 1'b0});
    `CHK(ocr, 1'b0)
    @(posedge clk);
    ctrl <= '{enhanced_calibration_trigger: 1'b1, default: 1'b0};
    @(posedge clk);
    #1;
    `CHK(ecs, 1'b1)
    @(posedge clk);
    #1;
    `CHK(ecs, 1'b0)
    setc('{analog_powerdown: 1'b1, default: 1'b0});
    `CHK(pwr, 4'hc)
    setc('{digital_powerdown: 1'b1, default: 1'b0});
    `CHK(pwr, 4'h3)
    conv(20'h00600);
    rd_chk(SEL_RES_UP, 16'h0050);
    final_report();
  end
endmodule : adc_result_display_data_path_test
